/* hdl/lfc_ctrl.sv */
// Host controller for a 9-bit dual-port queue/stack buffer chip.
// Assumes the chip's pins are wired directly; software drives it over AHB-Lite.
`timescale 1ns/1ps
module lfc_ctrl (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Buffer chip pins
    input wire lfc_pkg::lfc_pins_i_t pins_i,
    output lfc_pkg::lfc_pins_o_t pins_o,
    // Interrupt
    output logic irq
);
    import lfc_pkg::*;

    lfc_ctrl_st_t s_r;
    lfc_ctrl_st_t s_nxt;
    lfc_regbus_t rb;
    lfc_pins_i_t ps;
    logic [31:0] rd_data;
    logic busy;

    lfc_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rb(rb),
        .rd_data(rd_data)
    );

    // Every chip input is asynchronous to hclk
    lfc_sync #(
        .W($bits(lfc_pins_i_t))
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(pins_i),
        .q(ps)
    );

    // Any state but idle owns the pins; CTRL and CMD defer to it
    assign busy = (s_r.st != S_IDLE);

    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (rb.raddr)
            OFS_CTRL:
                rd_data[CTRL_W-1:0] = s_r.ctrl;
            OFS_CMD:
                rd_data = 32'h0000_0000;
            OFS_STATUS:
            begin
                rd_data[ST_BUSY] = busy;
                rd_data[ST_EMPTY] = ps.empty;
                rd_data[ST_FULL] = ps.full;
            end
            OFS_RDATA:
                rd_data[WORD_W-1:0] = s_r.rdata;
            OFS_INT_STAT:
                rd_data[INT_W-1:0] = s_r.istat;
            OFS_INT_MASK:
                rd_data[INT_W-1:0] = s_r.mask;
            default:
                rd_data = 32'h0000_0000;
        endcase
    end

    logic [INT_W-1:0] ev;
    logic [INT_W-1:0] w1c;
    logic go_wr;
    logic go_rd;
    logic new_dir;
    logic a_to_b;
    logic lifo;

    always_comb
    begin
        s_nxt = s_r;
        ev = '0;
        w1c = '0;
        go_wr = 1'b0;
        go_rd = 1'b0;
        new_dir = 1'b0;
        lifo = s_r.ctrl[CTRL_LIFO];
        a_to_b = s_r.ctrl[CTRL_A_TO_B];

        // Rising flag edges become interrupt events
        // Synced copies only; raw pins may glitch mid-access
        s_nxt.empty_q = ps.empty;
        s_nxt.full_q = ps.full;
        ev[INT_EMPTY] = ps.empty && !s_r.empty_q;
        ev[INT_FULL] = ps.full && !s_r.full_q;

        if (rb.wr)
        begin
            case (rb.addr)
                OFS_CTRL:
                begin
                    // Mode change mid-access would glitch the pins
                    if (!busy)
                        s_nxt.ctrl = rb.wdata[CTRL_W-1:0];
                end
                OFS_INT_MASK:
                    s_nxt.mask = rb.wdata[INT_W-1:0];
                OFS_INT_STAT:
                    w1c = rb.wdata[INT_W-1:0];
                OFS_CMD:
                begin
                    if (busy)
                        ev[INT_REFUSED] = 1'b1;
                    else if (rb.wdata[CMD_CLR])
                    begin
                        s_nxt.st = S_CLEAR;
                        s_nxt.cnt = MR_LD;
                        s_nxt.pins.master_clear = 1'b1;
                    end
                    else if (rb.wdata[CMD_WR])
                    begin
                        if (ps.full)
                            ev[INT_REFUSED] = 1'b1;
                        else
                            go_wr = 1'b1;
                    end
                    else if (rb.wdata[CMD_RD])
                    begin
                        if (ps.empty)
                            ev[INT_REFUSED] = 1'b1;
                        else
                            go_rd = 1'b1;
                    end
                end
                default:
                    ev = ev;
            endcase
        end

        if (go_wr || go_rd)
        begin
            s_nxt.op_wr = go_wr;
            s_nxt.op_rd = go_rd;
            s_nxt.pins.port_a_lines_o = rb.wdata[WORD_W-1:0];
            s_nxt.pins.port_b_lines_o = rb.wdata[WORD_W-1:0];
            if (lifo)
            begin
                s_nxt.use_b = s_r.ctrl[CTRL_PORT_B];
                // Port B reads with direction high, so its stack sense is inverted
                if (s_r.ctrl[CTRL_PORT_B])
                    new_dir = !go_wr;
                else
                    new_dir = go_wr;
            end
            else
            begin
                new_dir = a_to_b;
                // Queue loads on the writing side and removes on the other
                if (go_wr)
                    s_nxt.use_b = !a_to_b;
                else
                    s_nxt.use_b = a_to_b;
            end
            s_nxt.pins.direction = new_dir;
            s_nxt.st = S_DIR;
            // Direction needs its setup time only when it actually moves
            s_nxt.cnt = (new_dir != s_r.pins.direction) ? DIR_LD : CNT_ZERO;
        end

        case (s_r.st)
            S_IDLE:
            begin
                // Counter is loaded by the command decode above
                s_nxt.cnt = s_nxt.cnt;
            end
            S_CLEAR:
            begin
                if (s_r.cnt == CNT_ZERO)
                begin
                    s_nxt.pins.master_clear = 1'b0;
                    s_nxt.st = S_REC;
                    s_nxt.cnt = REC_LD;
                    s_nxt.op_wr = 1'b0;
                    s_nxt.op_rd = 1'b0;
                end
                else
                    s_nxt.cnt = s_r.cnt - 8'h01;
            end
            S_DIR:
            begin
                if (s_r.cnt == CNT_ZERO)
                begin
                    s_nxt.st = S_LOW;
                    s_nxt.cnt = LOW_LD;
                    s_nxt.pins.port_a_select_n = s_r.use_b;
                    s_nxt.pins.port_b_select_n = !s_r.use_b;
                    // Data is on the lines well before the rising select edge
                    s_nxt.pins.port_a_lines_oe = s_r.op_wr && !s_r.use_b;
                    s_nxt.pins.port_b_lines_oe = s_r.op_wr && s_r.use_b;
                end
                else
                    s_nxt.cnt = s_r.cnt - 8'h01;
            end
            S_LOW:
            begin
                if (s_r.cnt == CNT_ZERO)
                begin
                    s_nxt.pins.port_a_select_n = 1'b1;
                    s_nxt.pins.port_b_select_n = 1'b1;
                    // Sampled last, while the select is still low
                    if (s_r.op_rd && s_r.use_b)
                        s_nxt.rdata = ps.port_b_lines_i;
                    else if (s_r.op_rd)
                        s_nxt.rdata = ps.port_a_lines_i;
                    s_nxt.st = S_REC;
                    s_nxt.cnt = REC_LD;
                end
                else
                    s_nxt.cnt = s_r.cnt - 8'h01;
            end
            S_REC:
            begin
                // Hold write data past the rising edge, then float
                if (s_r.cnt == HOLD_END)
                begin
                    s_nxt.pins.port_a_lines_oe = 1'b0;
                    s_nxt.pins.port_b_lines_oe = 1'b0;
                end
                // Wait covers cycle time and flag settling before a new access
                if (s_r.cnt == CNT_ZERO)
                begin
                    s_nxt.st = S_IDLE;
                    ev[INT_DONE] = 1'b1;
                end
                else
                    s_nxt.cnt = s_r.cnt - 8'h01;
            end
            default:
            begin
                s_nxt.st = S_IDLE;
                s_nxt.cnt = CNT_ZERO;
            end
        endcase

        s_nxt.pins.depth_132 = s_nxt.ctrl[CTRL_DEPTH];
        // A new event wins over a simultaneous clear
        s_nxt.istat = (s_r.istat & ~w1c) | ev;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.mask <= MASK_RST;
            s_r.pins.direction <= CTRL_RST[CTRL_A_TO_B];
            s_r.pins.port_a_select_n <= 1'b1;
            s_r.pins.port_b_select_n <= 1'b1;
            s_r.pins.depth_132 <= CTRL_RST[CTRL_DEPTH];
        end
        else if (ce)
            s_r <= s_nxt;
    end

    assign pins_o = s_r.pins;
    // Level output; software removes the cause by a W1C write
    assign irq = |(s_r.istat & s_r.mask);
endmodule : lfc_ctrl

/* hdl/lfc_pkg.sv */
// Constants, register map and carrier types of the buffer-chip controller.
// Assumes a 20 MHz hclk; all pin timing below is counted in hclk cycles.
package lfc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SYNC_STAGES = 2;
    localparam int WORD_W = 9;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 8;
    localparam int INT_W = 4;
    localparam int CTRL_W = 4;

    // Pin timing of the slowest speed grade, in ns
    localparam int T_MR_NS = 400;
    localparam int T_CSL_NS = 600;
    localparam int T_CSH_NS = 600;
    localparam int T_CY_NS = 1540;
    localparam int T_DIR_NS = 1500;
    localparam int T_DV_NS = 550;
    localparam int T_DH_NS = 150;
    localparam int T_FV_NS = 550;

    // Least times, rounded up to whole cycles
    localparam int MR_CYC = (T_MR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSL_CYC = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSH_CYC = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CY_CYC = (T_CY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIR_CYC = (T_DIR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DV_CYC = (T_DV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FV_CYC = (T_FV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Select low long enough for read data to cross the synchroniser
    localparam int LOW_CYC = (CSL_CYC > DV_CYC + SYNC_STAGES) ? CSL_CYC : DV_CYC + SYNC_STAGES;
    localparam int REC_A = (CSH_CYC > FV_CYC + SYNC_STAGES) ? CSH_CYC : FV_CYC + SYNC_STAGES;
    localparam int REC_CYC = (REC_A > CY_CYC - LOW_CYC) ? REC_A : CY_CYC - LOW_CYC;

    typedef logic [CNT_W-1:0] lfc_cnt_t;
    localparam lfc_cnt_t MR_LD = lfc_cnt_t'(MR_CYC - 1);
    localparam lfc_cnt_t DIR_LD = lfc_cnt_t'(DIR_CYC - 1);
    localparam lfc_cnt_t LOW_LD = lfc_cnt_t'(LOW_CYC - 1);
    localparam lfc_cnt_t REC_LD = lfc_cnt_t'(REC_CYC - 1);
    localparam lfc_cnt_t HOLD_END = lfc_cnt_t'(REC_CYC - DH_CYC);
    localparam lfc_cnt_t CNT_ZERO = 8'h00;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RDATA = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h14;

    // Field positions
    localparam int CTRL_LIFO = 0;
    localparam int CTRL_DEPTH = 1;
    localparam int CTRL_PORT_B = 2;
    localparam int CTRL_A_TO_B = 3;
    localparam int CMD_WR = 16;
    localparam int CMD_RD = 17;
    localparam int CMD_CLR = 18;
    localparam int ST_BUSY = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_FULL = 2;
    localparam int INT_DONE = 0;
    localparam int INT_EMPTY = 1;
    localparam int INT_FULL = 2;
    localparam int INT_REFUSED = 3;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h8;
    localparam logic [INT_W-1:0] MASK_RST = 4'h0;

    typedef logic [WORD_W-1:0] lfc_word_t;

    typedef enum logic [2:0] {S_IDLE, S_CLEAR, S_DIR, S_LOW, S_REC} lfc_state_t;

    typedef struct packed {
        logic direction;
        logic port_a_select_n;
        logic port_b_select_n;
        logic master_clear;
        logic depth_132;
        lfc_word_t port_a_lines_o;
        logic port_a_lines_oe;
        lfc_word_t port_b_lines_o;
        logic port_b_lines_oe;
    } lfc_pins_o_t;

    typedef struct packed {
        lfc_word_t port_a_lines_i;
        lfc_word_t port_b_lines_i;
        logic empty;
        logic full;
    } lfc_pins_i_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic [ADDR_W-1:0] raddr;
    } lfc_regbus_t;

    typedef struct packed {
        lfc_state_t st;
        lfc_cnt_t cnt;
        logic [CTRL_W-1:0] ctrl;
        logic [INT_W-1:0] mask;
        logic [INT_W-1:0] istat;
        logic op_wr;
        logic op_rd;
        logic use_b;
        lfc_word_t rdata;
        logic empty_q;
        logic full_q;
        lfc_pins_o_t pins;
    } lfc_ctrl_st_t;
endpackage : lfc_pkg

/* hdl/lfc_sync.sv */
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; words are sampled only once stable.
`timescale 1ns/1ps
module lfc_sync #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import lfc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lfc_sync_st_t;

    lfc_sync_st_t s_r;
    lfc_sync_st_t s_nxt;

    always_comb
    begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    assign q = s_r.s2;
endmodule : lfc_sync

/* hdl/lfc_ahb.sv */
// AHB-Lite slave front end: zero wait states, OKAY only.
// Assumes single word transfers; read data is registered in the address phase.
`timescale 1ns/1ps
module lfc_ahb (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    output lfc_pkg::lfc_regbus_t rb,
    input wire logic [31:0] rd_data
);
    import lfc_pkg::*;

    typedef struct packed {
        logic wpend;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] rdata;
    } lfc_ahb_st_t;

    lfc_ahb_st_t s_r;
    lfc_ahb_st_t s_nxt;
    logic take;

    // Only whole-word transfers are issued, so hsize is not decoded
    assign take = hsel && htrans[1] && hready;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wpend = take && hwrite;
        if (take)
            s_nxt.waddr = haddr[ADDR_W-1:0];
        if (take && !hwrite)
            s_nxt.rdata = rd_data;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    always_comb
    begin
        rb.wr = s_r.wpend && ce;
        rb.addr = s_r.waddr;
        rb.wdata = hwdata;
        rb.raddr = haddr[ADDR_W-1:0];
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
endmodule : lfc_ahb

/* sim/lfc_chip_model.sv */
// Behavioural model of the 9-bit dual-port queue/stack buffer chip.
// Assumes its pins are wired straight to the controller; it has no clock.
`timescale 1ns/1ps
module lfc_chip_model (
    // From controller
    input wire lfc_pkg::lfc_pins_o_t po,
    // To controller
    output lfc_pkg::lfc_pins_i_t pi
);
    import lfc_pkg::*;
    int dv_ns = 100;
    lfc_word_t q[$];
    lfc_word_t dout[2] = '{9'h0a5, 9'h15a};
    bit low[2];
    bit last_b;
    logic empty_r = 1'b1;
    logic full_r = 1'b0;
    // Host drive wins on the port it loads
    assign pi = {po.port_a_lines_oe ? po.port_a_lines_o : dout[0],
        po.port_b_lines_oe ? po.port_b_lines_o : dout[1], empty_r, full_r};
    function automatic bit sel(bit p);
        return p ? po.port_b_select_n : po.port_a_select_n;
    endfunction : sel
    function automatic int cap();
        return po.depth_132 ? 132 : 128;
    endfunction : cap
    task automatic flags();
        empty_r = (q.size() == 0);
        full_r = (q.size() >= cap());
    endtask : flags
    task automatic fall(bit p);
        lfc_word_t w;
        low[p] = 1'b1;
        w = (last_b == p) ? q[$] : q[0];
        #(dv_ns);
        if (!sel(p) && po.direction == p && q.size() > 0)
            dout[p] = w;
    endtask : fall
    task automatic rise(bit p);
        if (!low[p])
            return;
        low[p] = 1'b0;
        // Undriven lines show garbage, not the old word
        dout[p] = ~dout[p];
        if (po.direction == p && q.size() > 0)
        begin
            if (last_b == p)
                void'(q.pop_back());
            else
                void'(q.pop_front());
        end
        else if (po.direction != p && q.size() < cap())
        begin
            q.push_back(p ? po.port_b_lines_o : po.port_a_lines_o);
            last_b = p;
        end
        #(dv_ns);
        flags();
    endtask : rise
    always @(negedge po.port_a_select_n) fall(1'b0);
    always @(negedge po.port_b_select_n) fall(1'b1);
    always @(posedge po.port_a_select_n) rise(1'b0);
    always @(posedge po.port_b_select_n) rise(1'b1);
    always @(posedge po.master_clear)
    begin
        q.delete();
        #(dv_ns);
        flags();
    end
endmodule : lfc_chip_model

/* sim/lfc_ctrl_monitor.sv */
// Checker on the pins and bus answer of the buffer-chip controller.
// Assumes it is bound into lfc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module lfc_ctrl_mon (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched outputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire lfc_pkg::lfc_pins_o_t pins_o
);
    import lfc_pkg::*;
    logic sa;
    logic sb;
    logic [7:0] low_n;
    assign sa = pins_o.port_a_select_n;
    assign sb = pins_o.port_b_select_n;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            low_n <= 8'h00;
        else if (sa && sb)
            low_n <= 8'h00;
        else
            low_n <= low_n + 8'h01;
    end
    chk_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    chk_one_port: assert property (sa || sb)
        else $error("both selects low");
    chk_low_width: assert property (
        ($rose(sa) || $rose(sb)) |-> low_n == LOW_CYC) else $error("select width wrong");
    chk_clear_width: assert property (
        $rose(pins_o.master_clear) |-> pins_o.master_clear[*8] ##1 !pins_o.master_clear)
        else $error("clear pulse width wrong");
    chk_clear_idle: assert property (pins_o.master_clear |-> sa && sb)
        else $error("select during clear");
    chk_oe_a_dir: assert property (pins_o.port_a_lines_oe |-> pins_o.direction)
        else $error("port a driven with direction low");
    chk_oe_b_dir: assert property (pins_o.port_b_lines_oe |-> !pins_o.direction)
        else $error("port b driven with direction high");
    chk_dir_steady: assert property ((!sa || !sb) |-> $stable(pins_o.direction))
        else $error("direction moved during access");
    chk_dir_setup: assert property ($changed(pins_o.direction) |-> (sa && sb)[*8])
        else $error("select too soon after direction");
    chk_data_hold: assert property (
        ($rose(sa) && pins_o.port_a_lines_oe) |->
        pins_o.port_a_lines_oe[*3] ##[1:2] !pins_o.port_a_lines_oe)
        else $error("load data hold wrong");
    chk_data_steady: assert property (
        (!sa && !$past(sa) && pins_o.port_a_lines_oe) |-> $stable(pins_o.port_a_lines_o))
        else $error("load data moved");
    cov_a: cover property ($rose(sa));
    cov_b: cover property ($rose(sb));
    cov_clr: cover property ($rose(pins_o.master_clear));
endmodule : lfc_ctrl_mon
bind lfc_ctrl lfc_ctrl_mon i_mon (.hclk, .hresetn, .hreadyout, .hresp, .pins_o);

/* sim/testbench.sv */
// Self-checking bench: AHB-Lite master, queue model, chip model on pins.
// Assumes a 20 MHz hclk and the chip model answering within 550 ns.
`timescale 1ns/1ps
module testbench;
    import lfc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    lfc_pins_i_t pins_i;
    lfc_pins_o_t pins_o;
    int err_count = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h5483;
    logic [31:0] r;
    int mq[$];
    bit lifo;
    int cap;
    logic [3:0] modes[4] = '{4'h8, 4'h0, 4'h1, 4'h5};
    logic [3:0] depths[2] = '{4'h8, 4'ha};
    always #25 hclk = ~hclk;
    lfc_ctrl i_dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
        .pins_i, .pins_o, .irq);
    lfc_chip_model i_chip (.po(pins_o), .pi(pins_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic ahb(bit w, logic [7:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic cmd(logic [31:0] c, bit refd);
        int n;
        ahb(1'b1, OFS_CMD, c);
        n = 0;
        do
        begin
            ahb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
        while (r[ST_BUSY] && n < 100);
        cmp("busy", 32'h0, {31'h0, r[ST_BUSY]});
        ahb(1'b0, OFS_INT_STAT, 32'h0);
        cmp("istat", refd ? 32'h8 : 32'h1, r & (refd ? 32'h8 : 32'h9));
        ahb(1'b1, OFS_INT_STAT, 32'hf);
    endtask : cmd
    task automatic op(bit wr);
        logic [8:0] d;
        bit refd;
        int e;
        d = 9'(rnd());
        refd = wr ? mq.size() >= cap : mq.size() == 0;
        cmd(wr ? (32'h10000 | 32'(d)) : 32'h20000, refd);
        if (!refd && wr)
            mq.push_back(d);
        else if (!refd)
        begin
            e = lifo ? mq.pop_back() : mq.pop_front();
            ahb(1'b0, OFS_RDATA, 32'h0);
            cmp("rdata", e, r);
        end
    endtask : op
    task automatic cfg(logic [3:0] c);
        ahb(1'b1, OFS_CTRL, 32'(c));
        ahb(1'b0, OFS_CTRL, 32'h0);
        cmp("ctrl", 32'(c), r);
        lifo = c[CTRL_LIFO];
        cap = c[CTRL_DEPTH] ? 132 : 128;
        cmd(32'h40000, 1'b0);
        mq.delete();
        ahb(1'b0, OFS_STATUS, 32'h0);
        cmp("status", 32'h2, r);
    endtask : cfg
    task automatic end_sim();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        #3_000_000;
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, OFS_CTRL, 32'h0);
        cmp("ctrl_rst", 32'(CTRL_RST), r);
        ahb(1'b0, OFS_INT_MASK, 32'h0);
        cmp("mask_rst", 32'(MASK_RST), r);
        ahb(1'b1, 8'h40, 32'hffff);
        ahb(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h0, r);
        // Odd passes use a slow chip to stress the read path
        foreach (modes[i])
        begin
            i_chip.dv_ns = (i % 2) ? 500 : 100;
            cfg(modes[i]);
            repeat (4) op(1'b1);
            op(1'b0);
            repeat (2) op(1'b1);
            repeat (6) op(1'b0);
        end
        foreach (depths[i])
        begin
            cfg(depths[i]);
            repeat (cap - 1) op(1'b1);
            ahb(1'b0, OFS_STATUS, 32'h0);
            cmp("partial", 32'h0, r);
            op(1'b1);
            ahb(1'b0, OFS_STATUS, 32'h0);
            cmp("full", 32'h4, r);
            op(1'b1);
        end
        ahb(1'b1, OFS_CMD, 32'h10000);
        ahb(1'b1, OFS_INT_MASK, 32'h8);
        repeat (2) @(negedge hclk);
        cmp("irq_on", 32'h1, 32'(irq));
        ahb(1'b1, OFS_INT_MASK, 32'h0);
        repeat (2) @(negedge hclk);
        cmp("irq_mask", 32'h0, 32'(irq));
        ahb(1'b1, OFS_INT_MASK, 32'h8);
        ahb(1'b1, OFS_INT_STAT, 32'h8);
        repeat (2) @(negedge hclk);
        cmp("irq_clr", 32'h0, 32'(irq));
        end_sim();
    end
endmodule : testbench
